// ==== src/sfr_stall_fault_response.sv ====
// Contract
// R1: motor stall on speed, no-motor or back-EMF
// R2: motor modes 0000/0001: Hi-Z, report, latched
// R3: motor modes 0100/0101: Hi-Z, report, timed retry
// R4: motor 0010 latched / 0110 retry high-side brake
// R5: motor 0011 latched / 0111 retry low-side brake
// R6: hardware fault when sense exceeds hardware threshold
// R7: hardware modes 0000/0001: Hi-Z, report, latched
// R8: hardware modes 0100/0101: Hi-Z, report, retry
// R9: current faults 0010/0110 high-side brake latched/retry
// R10: current faults 0011/0111 low-side brake latched/retry
// R11: software fault when sense exceeds software threshold
// R12: software modes 0000/0001: Hi-Z, report, latched
// R13: software modes 0100/0101: Hi-Z, report, retry
// R14: 1000 report only; 1xx1 ignored entirely
// R15: latched holds until clear; latched beats retry
// R16: priority latched, retry, then report-only
// R17: actionable faults pull fault pin, alarm if enabled
// R18: clear may take up to 200 ms
`timescale 1ns/1ps
module sfr_stall_fault_response #(
	parameter int RETRY_CYCLES = sfr_pkg::SFR_RETRY_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire sfr_pkg::sfr_stall_s stall_cond,
	input wire logic [sfr_pkg::SFR_SENSE_W-1:0] phase_sense_voltage,
	input wire logic [sfr_pkg::SFR_SENSE_W-1:0] hardware_stall_current_threshold,
	input wire logic [sfr_pkg::SFR_SENSE_W-1:0] software_stall_current_threshold,
	input wire sfr_pkg::sfr_modes_s modes,
	input wire logic alarm_pin_en,
	input wire logic fault_clear_cmd,
	output sfr_pkg::sfr_fet_e fet_state,
	output logic fault_out_n,
	output logic alarm_out,
	output sfr_pkg::sfr_flags_s controller_fault_flags
);
	import sfr_pkg::*;

	// ========================================
	// mode decoding
	function automatic logic mode_mute(input logic [3:0] m);
		return m[SFR_MODE_NOACT_BIT] & m[SFR_MODE_MUTE_BIT];
	endfunction

	function automatic logic mode_noact(input logic [3:0] m);
		return m[SFR_MODE_NOACT_BIT] & ~m[SFR_MODE_MUTE_BIT];
	endfunction

	function automatic logic mode_retry(input logic [3:0] m);
		return ~m[SFR_MODE_NOACT_BIT] & m[SFR_MODE_RETRY_BIT];
	endfunction

	function automatic sfr_fet_e mode_fet(input logic [3:0] m);
		if (m[SFR_MODE_NOACT_BIT]) begin
			return SFR_FET_ACTIVE;
		end
		unique case (m[1:0])
			2'h2: return SFR_FET_HS_BRAKE;
			2'h3: return SFR_FET_LS_BRAKE;
			default: return SFR_FET_HIZ;
		endcase
	endfunction

	// ========================================
	// fault detection
	logic [3:0] mode_v [SFR_NF];
	logic [SFR_NF-1:0] event_v;
	logic [SFR_NF-1:0] retry_cond_v;

	always_comb begin
		mode_v[SFR_MTR] = modes.motor_stall_response_mode;
		mode_v[SFR_HW] = modes.hardware_stall_response_mode;
		mode_v[SFR_SW] = modes.software_stall_response_mode;
		event_v[SFR_MTR] = stall_cond.abnormal_speed | stall_cond.no_motor | stall_cond.abnormal_bemf; // R1
		event_v[SFR_HW] = phase_sense_voltage > hardware_stall_current_threshold; // R6
		event_v[SFR_SW] = phase_sense_voltage > software_stall_current_threshold; // R11
		for (int i = 0; i < SFR_NF; i++) begin
			retry_cond_v[i] = event_v[i] & mode_retry(mode_v[i]);
		end
	end

	// ========================================
	// state
	sfr_state_s st_ff;
	sfr_state_s nxt_st;
	logic any_act;
	logic found;

	always_comb begin
		nxt_st = st_ff;
		any_act = 1'b0;
		found = 1'b0;
		// clear acts in one cycle, well inside the allowed 200 ms
		if (fault_clear_cmd) begin
			nxt_st.lat = SFR_FLAGS_RST; // R15 R18
			nxt_st.rep = SFR_FLAGS_RST;
		end
		// sets come after the clear so a coincident event is kept
		for (int i = 0; i < SFR_NF; i++) begin
			if (event_v[i] && !mode_mute(mode_v[i])) begin // R14
				if (mode_noact(mode_v[i])) begin
					nxt_st.rep[i] = 1'b1; // R14
				end else if (mode_retry(mode_v[i])) begin
					nxt_st.rty[i] = 1'b1; // R3 R8 R13
				end else begin
					nxt_st.lat[i] = 1'b1; // R2 R7 R12
				end
			end
		end
		// retry time runs only once every retry condition has gone
		if (nxt_st.rty == SFR_FLAGS_RST || (|retry_cond_v)) begin
			nxt_st.retry_cnt = SFR_CNT_RST;
		end else if (st_ff.retry_cnt >= SFR_CNT_W'(RETRY_CYCLES - 1)) begin
			nxt_st.rty = SFR_FLAGS_RST; // R3 R8 R13
			nxt_st.retry_cnt = SFR_CNT_RST;
		end else begin
			nxt_st.retry_cnt = st_ff.retry_cnt + SFR_CNT_W'(1);
		end
		// latched faults steer the stage before retry faults; motor slot first
		nxt_st.fet = SFR_FET_ACTIVE;
		for (int i = 0; i < SFR_NF; i++) begin
			if (nxt_st.lat[i] && !found) begin
				nxt_st.fet = mode_fet(mode_v[i]); // R2 R4 R5 R7 R9 R10 R12 R15 R16
				found = 1'b1;
			end
		end
		for (int i = 0; i < SFR_NF; i++) begin
			if (nxt_st.rty[i] && !found) begin
				nxt_st.fet = mode_fet(mode_v[i]); // R3 R4 R5 R8 R9 R10 R13 R16
				found = 1'b1;
			end
		end
		any_act = |(nxt_st.lat | nxt_st.rty);
		nxt_st.fault_n = !(any_act || ((|nxt_st.rep) && !alarm_pin_en)); // R17
		nxt_st.alarm = alarm_pin_en && (any_act || (|nxt_st.rep)); // R17
		nxt_st.flags = nxt_st.lat | nxt_st.rty | nxt_st.rep;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			st_ff.lat <= SFR_FLAGS_RST;
			st_ff.rty <= SFR_FLAGS_RST;
			st_ff.rep <= SFR_FLAGS_RST;
			st_ff.retry_cnt <= SFR_CNT_RST;
			st_ff.fet <= SFR_FET_ACTIVE;
			st_ff.fault_n <= SFR_FAULT_N_RST;
			st_ff.alarm <= SFR_ALARM_RST;
			st_ff.flags <= SFR_FLAGS_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign fet_state = st_ff.fet;
	assign fault_out_n = st_ff.fault_n;
	assign alarm_out = st_ff.alarm;
	assign controller_fault_flags = st_ff.flags;

	// ========================================
	// checks
	motor_detect_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
		(|stall_cond) && modes.motor_stall_response_mode == 4'h0
		|=> st_ff.lat[SFR_MTR] && !fault_out_n)
		else $error("motor stall not latched");

	hw_detect_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
		event_v[SFR_HW] && !mode_mute(modes.hardware_stall_response_mode)
		|=> controller_fault_flags.hardware_stall_current_fault)
		else $error("hardware stall fault not flagged");

	sw_retry_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9 R13
		event_v == 3'h4 && modes.software_stall_response_mode == 4'h6
		&& st_ff.lat == 3'h0 && st_ff.rty[1:0] == 2'h0
		|=> st_ff.rty[SFR_SW] && fet_state == SFR_FET_HS_BRAKE)
		else $error("software retry brake not applied");

	latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
		st_ff.lat[SFR_MTR] && !fault_clear_cmd |=> st_ff.lat[SFR_MTR])
		else $error("latched fault dropped without clear");

	clear_done_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R18
		fault_clear_cmd && event_v == 3'h0 |=> st_ff.lat == 3'h0 && st_ff.rep == 3'h0)
		else $error("clear did not remove latched faults");

	latch_first_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
		st_ff.lat[SFR_MTR] |-> fet_state == mode_fet($past(modes.motor_stall_response_mode)))
		else $error("latched motor fault not steering stage");

	retry_time_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
		$fell(|st_ff.rty) && $past(rst_n)
		|-> $past(st_ff.retry_cnt) == SFR_CNT_W'(RETRY_CYCLES - 1))
		else $error("retry ended before retry time");

	fault_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
		(|(st_ff.lat | st_ff.rty)) |-> !fault_out_n && (alarm_out == $past(alarm_pin_en)))
		else $error("actionable fault not on fault pin");

	mute_quiet_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
		st_ff.flags == 3'h0 && mode_mute(modes.hardware_stall_response_mode)
		&& event_v == 3'h2 |=> fault_out_n && fet_state == SFR_FET_ACTIVE)
		else $error("muted fault acted");

	motor_ls_retry_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
		event_v[SFR_MTR] && modes.motor_stall_response_mode == 4'h7
		|=> st_ff.rty[SFR_MTR] && (fet_state == SFR_FET_LS_BRAKE || st_ff.lat != 3'h0))
		else $error("motor retry low-side brake not applied");

	hw_brake_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
		event_v[SFR_HW] && modes.hardware_stall_response_mode == 4'h3
		|=> st_ff.lat[SFR_HW] && (fet_state == SFR_FET_LS_BRAKE || st_ff.lat[SFR_MTR]))
		else $error("hardware latched low-side brake not applied");

	report_only_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
		event_v[SFR_MTR] && modes.motor_stall_response_mode == SFR_MODE_REPORT_ONLY
		|=> st_ff.rep[SFR_MTR] && controller_fault_flags.motor_stall_fault)
		else $error("report-only motor fault not flagged");

	report_pin_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
		(|st_ff.rep) && st_ff.lat == 3'h0 && st_ff.rty == 3'h0
		|-> fault_out_n == $past(alarm_pin_en) && alarm_out == $past(alarm_pin_en))
		else $error("report-only fault on wrong pin");

	retry_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3 R8 R13
		st_ff.retry_cnt <= SFR_CNT_W'(RETRY_CYCLES - 1))
		else $error("retry counter ran past retry time");

endmodule

// ==== src/sfr_pkg.sv ====
package sfr_pkg;

	// ========================================
	// fault slots and field layout
	localparam int SFR_NF = 3;
	localparam int SFR_MTR = 0;
	localparam int SFR_HW = 1;
	localparam int SFR_SW = 2;
	localparam int SFR_SENSE_W = 12;
	localparam int SFR_MODE_MUTE_BIT = 0;
	localparam int SFR_MODE_RETRY_BIT = 2;
	localparam int SFR_MODE_NOACT_BIT = 3;
	localparam logic [3:0] SFR_MODE_REPORT_ONLY = 4'h8;

	// ========================================
	// timing
	localparam int SFR_CLK_HZ = 25_000_000;
	localparam int SFR_RETRY_TIME_MS = 100;
	localparam int SFR_RETRY_CYC = SFR_RETRY_TIME_MS * (SFR_CLK_HZ / 1000);
	localparam int SFR_CLEAR_TIME_MS = 200;
	localparam int SFR_CNT_W = 32;

	// ========================================
	// types
	typedef enum logic [1:0] {
		SFR_FET_ACTIVE,
		SFR_FET_HIZ,
		SFR_FET_HS_BRAKE,
		SFR_FET_LS_BRAKE
	} sfr_fet_e;

	typedef struct packed {
		logic abnormal_speed;
		logic no_motor;
		logic abnormal_bemf;
	} sfr_stall_s;

	typedef struct packed {
		logic [3:0] software_stall_response_mode;
		logic [3:0] hardware_stall_response_mode;
		logic [3:0] motor_stall_response_mode;
	} sfr_modes_s;

	typedef struct packed {
		logic software_stall_current_fault;
		logic hardware_stall_current_fault;
		logic motor_stall_fault;
	} sfr_flags_s;

	typedef struct packed {
		logic [SFR_NF-1:0] lat;
		logic [SFR_NF-1:0] rty;
		logic [SFR_NF-1:0] rep;
		logic [SFR_CNT_W-1:0] retry_cnt;
		sfr_fet_e fet;
		logic fault_n;
		logic alarm;
		sfr_flags_s flags;
	} sfr_state_s;

	// ========================================
	// reset values
	localparam logic [SFR_NF-1:0] SFR_FLAGS_RST = 3'h0;
	localparam logic [SFR_CNT_W-1:0] SFR_CNT_RST = 32'h0;
	localparam logic SFR_FAULT_N_RST = 1'b1;
	localparam logic SFR_ALARM_RST = 1'b0;

endpackage

// ==== verification/sfr_power_stage_model.sv ====
`timescale 1ns/1ps
// ========================================
// power stage and motor seen from the sense amplifier
module sfr_power_stage_model (
	input wire logic sys_clk,
	input wire sfr_pkg::sfr_fet_e fet_state,
	input wire logic [2:0] lock_bits,
	input wire logic [11:0] load_level,
	output sfr_pkg::sfr_stall_s stall_cond,
	output logic [sfr_pkg::SFR_SENSE_W-1:0] phase_sense_voltage
);
	import sfr_pkg::*;
	// hi-z leaves no phase current, so a current fault drops once the bridge lets go
	always @(negedge sys_clk) begin
		stall_cond <= sfr_stall_s'(lock_bits);
		case (fet_state)
			SFR_FET_ACTIVE: phase_sense_voltage <= load_level;
			SFR_FET_HIZ: phase_sense_voltage <= 12'h000;
			default: phase_sense_voltage <= load_level >> 1;
		endcase
	end
endmodule

// ==== verification/tb.sv ====
`timescale 1ns/1ps
module tb;
	import sfr_pkg::*;
	localparam int RC = 20;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] lock_bits = 3'h0;
	logic [11:0] load_level = 12'h000;
	logic [11:0] hw_thr = 12'h000;
	logic [11:0] sw_thr = 12'h000;
	sfr_modes_s modes = '0;
	logic alarm_en = 1'b0;
	logic clr = 1'b0;
	sfr_stall_s stall_cond;
	logic [11:0] sense;
	sfr_fet_e fet_state;
	logic fault_out_n;
	logic alarm_out;
	sfr_flags_s flags;
	int mismatches = 0;
	int n_tests = 0;
	int lat, rty, rep, cnt;
	logic [3:0] e_fet, e_fn, e_al;
	logic [31:0] seed = 32'h56;
	logic [31:0] r;

	always #20 sys_clk = ~sys_clk;

	sfr_power_stage_model u_ps (.sys_clk(sys_clk), .fet_state(fet_state),
		.lock_bits(lock_bits), .load_level(load_level), .stall_cond(stall_cond),
		.phase_sense_voltage(sense));
	sfr_stall_fault_response #(.RETRY_CYCLES(RC)) u_dut (.sys_clk(sys_clk), .rst_n(rst_n),
		.stall_cond(stall_cond), .phase_sense_voltage(sense),
		.hardware_stall_current_threshold(hw_thr), .software_stall_current_threshold(sw_thr),
		.modes(modes), .alarm_pin_en(alarm_en), .fault_clear_cmd(clr),
		.fet_state(fet_state), .fault_out_n(fault_out_n), .alarm_out(alarm_out),
		.controller_fault_flags(flags));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %0h seen %0h", name, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ========================================
	// reference model, one step per rising edge
	function automatic logic [3:0] fet_of(input logic [3:0] m);
		return (m[1:0] == 2'h2) ? 4'h2 : (m[1:0] == 2'h3) ? 4'h3 : 4'h1;
	endfunction

	always @(posedge sys_clk) begin
		int ev, lm, rm, pm;
		logic [3:0] m;
		ev = {sense > sw_thr, sense > hw_thr, |stall_cond};
		lm = 0;
		rm = 0;
		pm = 0;
		for (int i = 0; i < 3; i++) begin
			m = modes[4*i +: 4];
			if (ev[i] && !(m[3] && m[0])) begin
				if (m[3]) pm[i] = 1;
				else if (m[2]) rm[i] = 1;
				else lm[i] = 1;
			end
		end
		// clear only drops faults whose cause is gone; a fresh event wins
		if (clr) begin
			lat &= ev;
			rep &= ev;
		end
		lat |= lm;
		rep |= pm;
		if (rm != 0) begin
			rty |= rm;
			cnt = 0;
		end else if (rty != 0) begin
			if (cnt == RC - 1) begin
				rty = 0;
				cnt = 0;
			end else cnt++;
		end
		if (!rst_n) begin
			lat = 0;
			rty = 0;
			rep = 0;
			cnt = 0;
		end
		e_fet = 4'h0;
		for (int i = 2; i >= 0; i--) if (rty[i]) e_fet = fet_of(modes[4*i +: 4]);
		for (int i = 2; i >= 0; i--) if (lat[i]) e_fet = fet_of(modes[4*i +: 4]);
		e_fn = 4'((lat | rty) == 0 && (rep == 0 || alarm_en));
		e_al = 4'(alarm_en && (lat | rty | rep) != 0);
	end

	// ========================================
	// every mode of every fault, random load, locks and clears
	initial begin
		repeat (5) @(negedge sys_clk);
		for (int s = 0; s < 64; s++) begin
			r = rnd();
			rst_n <= 1'b1;
			modes <= {4'(s + 11), 4'(s + 5), 4'(s)};
			hw_thr <= r[11:0];
			sw_thr <= r[23:12];
			alarm_en <= r[24];
			for (int c = 0; c < 80; c++) begin
				@(negedge sys_clk);
				check("fet", 4'(fet_state), e_fet);
				check("flags", 4'(flags), 4'(lat | rty | rep));
				check("fault_n", 4'(fault_out_n), e_fn);
				check("alarm", 4'(alarm_out), e_al);
				r = rnd();
				lock_bits <= (c < 40 && r[4:2] == 3'h0) ? r[7:5] : 3'h0;
				load_level <= (c < 40) ? r[19:8] : 12'h000;
				clr <= (r[30:27] == 4'h0);
			end
			rst_n <= 1'b0;
			@(negedge sys_clk);
		end
		report_and_stop();
	end

	initial begin
		#(40 * 64 * 82 * 2);
		mismatches++;
		$display("[ERR] watchdog expired before the tests ended");
		report_and_stop();
	end
endmodule
